// ==== design/adcw_pkg.sv ====
// Package with register map, field layout and types of the result and low threshold block
package adcw_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam int unsigned ADCW_IDX_W       = 6;
  localparam logic [5:0]  ADCW_IDX_TEMP    = 6'h0d;
  localparam logic [5:0]  ADCW_IDX_RES_LO  = 6'h10;
  localparam logic [5:0]  ADCW_IDX_RES_HI  = 6'h11;
  localparam logic [5:0]  ADCW_IDX_WLT_LO  = 6'h12;
  localparam logic [5:0]  ADCW_IDX_WLT_HI  = 6'h13;
  localparam logic [5:0]  ADCW_IDX_CTRL    = 6'h20;
  localparam logic [5:0]  ADCW_IDX_FLAGS   = 6'h21;
  localparam logic [5:0]  ADCW_IDX_MASK    = 6'h22;
  localparam int unsigned ADCW_ADDR_LSB    = 2;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int unsigned ADCW_CTRL_ACC_LSB  = 0;
  localparam int unsigned ADCW_CTRL_MODE_LSB = 3;
  localparam logic [2:0]  ADCW_ACC_LOG2_MAX  = 3'h6;
  localparam logic [7:0]  ADCW_BYTE_RST      = 8'h00;
  localparam logic [15:0] ADCW_WORD_RST      = 16'h0000;
  localparam logic [9:0]  ADCW_CODE_MAX      = 10'h3ff;
  localparam logic [9:0]  ADCW_CODE_MIN      = 10'h000;
  localparam logic [15:0] ADCW_ACC_MAX       = 16'hffc0;
  localparam logic [6:0]  ADCW_CNT_ONE       = 7'h01;
  localparam logic [6:0]  ADCW_CNT_RST       = 7'h00;

  // Window mode encodings
  localparam logic [1:0]  ADCW_MODE_OFF   = 2'h0;
  localparam logic [1:0]  ADCW_MODE_BELOW = 2'h1;
  localparam logic [1:0]  ADCW_MODE_ABOVE = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic window_match_flag;
    logic result_ready_flag;
  } adcw_flags_s;

  typedef struct packed {
    logic [1:0] window_mode_select;
    logic [2:0] acc_log2;
  } adcw_ctrl_s;

  typedef enum logic [1:0] {
    ADCW_ST_IDLE = 2'b01,
    ADCW_ST_ACC  = 2'b10
  } adcw_state_e;

endpackage : adcw_pkg

// ==== design/adcw_top.sv ====
// Result register, low threshold comparator, flags and APB slave of the converter
`timescale 1ns/10ps
`default_nettype none

module adcw_top
  import adcw_pkg::*;
#(
  parameter int unsigned CODE_IN_W = 12
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Conversion input, raw signed code before clamping
  input  wire logic                 conv_valid,
  input  wire logic signed [CODE_IN_W-1:0] conv_code,
  // Interrupt
  output logic                      irq
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic idx_is(input logic [7:0] a, input logic [5:0] idx);
    idx_is = (a[ADCW_ADDR_LSB +: ADCW_IDX_W] == idx);
  endfunction : idx_is

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [31:0]  prdata_ff;
  logic         pready_ff;
  logic         pslverr_ff;
  logic         irq_ff;
  logic [7:0]   temp_ff;
  logic [15:0]  result_ff;
  logic [15:0]  wlt_ff;
  adcw_ctrl_s   ctrl_ff;
  adcw_flags_s  flags_ff;
  adcw_flags_s  mask_ff;
  logic [15:0]  acc_ff;
  logic [6:0]   cnt_ff;
  adcw_state_e  state_ff;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire logic setup_ph  = psel & ~penable;
  wire logic done_ph   = psel & penable & pready_ff;
  wire logic wr_done   = done_ph & pwrite & pstrb[0];
  wire logic rd_done   = done_ph & ~pwrite;
  wire logic a_temp    = idx_is(paddr, ADCW_IDX_TEMP);
  wire logic a_res_lo  = idx_is(paddr, ADCW_IDX_RES_LO);
  wire logic a_res_hi  = idx_is(paddr, ADCW_IDX_RES_HI);
  wire logic a_wlt_lo  = idx_is(paddr, ADCW_IDX_WLT_LO);
  wire logic a_wlt_hi  = idx_is(paddr, ADCW_IDX_WLT_HI);
  wire logic a_ctrl    = idx_is(paddr, ADCW_IDX_CTRL);
  wire logic a_flags   = idx_is(paddr, ADCW_IDX_FLAGS);
  wire logic a_mask    = idx_is(paddr, ADCW_IDX_MASK);
  wire logic a_mapped  = a_temp | a_res_lo | a_res_hi | a_wlt_lo | a_wlt_hi | a_ctrl | a_flags | a_mask;
  wire logic res_read  = rd_done & (a_res_lo | a_res_hi);

  // Read data selection; high bytes of pairs return the shared temporary byte
  wire logic [7:0] rd_byte =
      a_temp   ? temp_ff :
      a_res_lo ? result_ff[7:0] :
      a_res_hi ? temp_ff :
      a_wlt_lo ? wlt_ff[7:0] :
      a_wlt_hi ? temp_ff :
      a_ctrl   ? {3'h0, ctrl_ff} :
      a_flags  ? {6'h00, flags_ff} :
      a_mask   ? {6'h00, mask_ff} : ADCW_BYTE_RST;

  // ****************************************************************
  // Conversion clamp and accumulation
  // ****************************************************************
  localparam logic signed [CODE_IN_W-1:0] CODE_MAX_S = CODE_IN_W'(signed'({1'b0, ADCW_CODE_MAX}));
  wire logic code_hi = (conv_code > CODE_MAX_S);
  wire logic code_lo = conv_code[CODE_IN_W-1];
  // Saturate to the 10-bit unsigned range
  wire logic [9:0] sat_code = code_hi ? ADCW_CODE_MAX :
                              code_lo ? ADCW_CODE_MIN : conv_code[9:0];
  wire logic [2:0] acc_log2 = (ctrl_ff.acc_log2 > ADCW_ACC_LOG2_MAX) ? ADCW_ACC_LOG2_MAX : ctrl_ff.acc_log2;
  wire logic [6:0] acc_target = 7'(ADCW_CNT_ONE << acc_log2);
  wire logic       first_smp = (state_ff == ADCW_ST_IDLE);
  // Unsigned sum; clamped codes keep it at or under the maximum total
  wire logic [15:0] acc_sum = (first_smp ? ADCW_WORD_RST : acc_ff) + {6'h00, sat_code};
  wire logic [6:0]  cnt_inc = cnt_ff + ADCW_CNT_ONE;
  wire logic        acc_end = conv_valid & (cnt_inc == acc_target);

  // Compare only the finished sum
  wire logic win_below = (acc_sum < wlt_ff);
  wire logic win_above = (acc_sum > wlt_ff);
  wire logic win_hit   = ((ctrl_ff.window_mode_select == ADCW_MODE_BELOW) & win_below) |
                         ((ctrl_ff.window_mode_select == ADCW_MODE_ABOVE) & win_above);
  wire logic set_match = acc_end & win_hit;
  wire logic set_ready = acc_end;

  // ****************************************************************
  // Next-state values
  // ****************************************************************
  wire adcw_flags_s wr1_clr = (wr_done & a_flags) ? adcw_flags_s'(pwdata[1:0]) : adcw_flags_s'(2'b00);
  wire adcw_flags_s nxt_flags;
  // Set beats clear; write zero leaves a bit alone
  assign nxt_flags.window_match_flag = set_match |
      (flags_ff.window_match_flag & ~wr1_clr.window_match_flag & ~res_read);
  assign nxt_flags.result_ready_flag = set_ready |
      (flags_ff.result_ready_flag & ~wr1_clr.result_ready_flag & ~res_read);
  wire adcw_flags_s nxt_mask = (wr_done & a_mask) ? adcw_flags_s'(pwdata[1:0]) : mask_ff;
  wire logic        nxt_irq  = |(nxt_flags & nxt_mask);

  // Temporary byte: loaded by direct write, threshold low-byte writes, and low-byte reads of pairs
  wire logic [7:0] nxt_temp =
      (wr_done & (a_temp | a_wlt_lo)) ? pwdata[7:0] :
      (rd_done & a_res_lo)            ? result_ff[15:8] :
      (rd_done & a_wlt_lo)            ? wlt_ff[15:8] : temp_ff;
  // High byte write commits the whole threshold at once
  wire logic [15:0] nxt_wlt = (wr_done & a_wlt_hi) ? {pwdata[7:0], temp_ff} : wlt_ff;
  wire adcw_ctrl_s  nxt_ctrl = (wr_done & a_ctrl) ? adcw_ctrl_s'(pwdata[4:0]) : ctrl_ff;
  wire logic [15:0] nxt_result = acc_end ? acc_sum : result_ff;
  wire logic [15:0] nxt_acc    = conv_valid ? acc_sum : acc_ff;
  wire logic [6:0]  nxt_cnt    = acc_end ? ADCW_CNT_RST : (conv_valid ? cnt_inc : cnt_ff);
  adcw_state_e      nxt_state_w;

  // Accumulation state
  always_comb begin
    case (state_ff)
      ADCW_ST_IDLE: nxt_state_w = (conv_valid & ~acc_end) ? ADCW_ST_ACC : ADCW_ST_IDLE;
      ADCW_ST_ACC:  nxt_state_w = acc_end ? ADCW_ST_IDLE : ADCW_ST_ACC;
      default:      nxt_state_w = ADCW_ST_IDLE;
    endcase
  end

  // ****************************************************************
  // APB answer registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= setup_ph;
      pslverr_ff <= setup_ph & ~a_mapped;
      prdata_ff  <= (setup_ph & ~pwrite) ? {24'h00_0000, rd_byte} : prdata_ff;
    end
  end

  // Register file and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_ff  <= ADCW_BYTE_RST;
      wlt_ff   <= ADCW_WORD_RST;
      ctrl_ff  <= adcw_ctrl_s'(5'h00);
      flags_ff <= adcw_flags_s'(2'b00);
      mask_ff  <= adcw_flags_s'(2'b00);
      irq_ff   <= 1'b0;
    end else begin
      temp_ff  <= nxt_temp;
      wlt_ff   <= nxt_wlt;
      ctrl_ff  <= nxt_ctrl;
      flags_ff <= nxt_flags;
      mask_ff  <= nxt_mask;
      irq_ff   <= nxt_irq;
    end
  end

  // Accumulator and result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ff <= ADCW_WORD_RST;
      acc_ff    <= ADCW_WORD_RST;
      cnt_ff    <= ADCW_CNT_RST;
      state_ff  <= ADCW_ST_IDLE;
    end else begin
      result_ff <= nxt_result;
      acc_ff    <= nxt_acc;
      cnt_ff    <= nxt_cnt;
      state_ff  <= nxt_state_w;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq     = irq_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_res_lo_read;
    rd_done && a_res_lo;
  endsequence

  sequence s_wlt_hi_write;
    wr_done && a_wlt_hi;
  endsequence

  res_hi_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_res_lo_read ##0 (!acc_end) |=> (temp_ff == result_ff[15:8]))
    else $error("Result high byte not latched into temporary byte");

  res_lo_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_res_lo_read and $stable(result_ff) |-> (prdata_ff[7:0] == result_ff[7:0]) && (prdata_ff[31:8] == 24'h00_0000))
    else $error("Result low byte read mismatch");

  single_width_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc_end && (acc_log2 == 3'h0) |=> (result_ff[15:10] == 6'h00))
    else $error("Single conversion wider than ten bits");

  acc_ceiling_a: assert property (@(posedge pclk) disable iff (!presetn)
    result_ff <= ADCW_ACC_MAX)
    else $error("Accumulated result above maximum total");

  wlt_commit_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_wlt_hi_write |=> (wlt_ff == {$past(pwdata[7:0]), $past(temp_ff)}))
    else $error("Threshold not committed from temporary byte");

  final_compare_a: assert property (@(posedge pclk) disable iff (!presetn)
    conv_valid && !acc_end && !res_read && !(wr_done && a_flags) && !flags_ff.window_match_flag
    |=> !flags_ff.window_match_flag)
    else $error("Window match set on an intermediate sample");

  match_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc_end && (ctrl_ff.window_mode_select == ADCW_MODE_BELOW) && (acc_sum < wlt_ff)
    |=> flags_ff.window_match_flag && flags_ff.result_ready_flag)
    else $error("Window match or ready flag missing after result");

  ready_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_res_lo_read ##0 !acc_end |=> (flags_ff == adcw_flags_s'(2'b00)))
    else $error("Result read did not clear flags");

  zero_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && a_flags && (pwdata[1:0] == 2'b00) && !acc_end |=> $stable(flags_ff))
    else $error("Writing zero changed a flag");

  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_ff == |(flags_ff & mask_ff))
    else $error("Interrupt level disagrees with masked flags");

  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph |=> pready_ff ##1 !pready_ff)
    else $error("Slave did not answer in one cycle");

  // ****************************************************************
  // Further checks on clamp, pairing, flags and bus answers
  // ****************************************************************
  // Raw code classes, worked out apart from the clamp logic
  wire logic       chk_code_neg  = conv_code[CODE_IN_W-1];
  wire logic       chk_code_over = ~conv_code[CODE_IN_W-1] & (|conv_code[CODE_IN_W-2:$bits(ADCW_CODE_MAX)]);
  wire logic [9:0] chk_code_raw  = conv_code[$bits(ADCW_CODE_MAX)-1:0];

  sequence s_single_end;
    acc_end && (acc_log2 == 3'h0);
  endsequence

  sequence s_flags_write;
    wr_done && a_flags;
  endsequence

  clamp_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_single_end ##0 chk_code_over |=> (result_ff == {6'h00, ADCW_CODE_MAX}))
    else $error("Code above range not held at top code");

  clamp_floor_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_single_end ##0 chk_code_neg |=> (result_ff == ADCW_WORD_RST))
    else $error("Negative code not held at zero");

  single_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_single_end ##0 (!chk_code_neg && !chk_code_over) |=> (result_ff == {6'h00, $past(chk_code_raw)}))
    else $error("Single code not passed through unchanged");

  res_write_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && (a_res_lo || a_res_hi) && !acc_end |=> $stable(result_ff))
    else $error("Write to read-only result changed it");

  res_hi_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_done && a_res_hi |-> (prdata_ff[7:0] == temp_ff))
    else $error("Result high byte not served from temporary byte");

  wlt_lo_stage_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && a_wlt_lo |=> (temp_ff == $past(pwdata[7:0])) && $stable(wlt_ff))
    else $error("Threshold low byte not staged in temporary byte");

  wlt_lo_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_done && a_wlt_lo |=> (temp_ff == wlt_ff[15:8]))
    else $error("Threshold high byte not latched on low byte read");

  strb_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
    done_ph && pwrite && !pstrb[0] |=> $stable(temp_ff) && $stable(wlt_ff) && $stable(ctrl_ff))
    else $error("Write without byte strobe took effect");

  above_hit_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc_end && (ctrl_ff.window_mode_select == ADCW_MODE_ABOVE) && (acc_sum > wlt_ff)
    |=> flags_ff.window_match_flag)
    else $error("Window match missing for result above threshold");

  mode_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc_end && (ctrl_ff.window_mode_select == ADCW_MODE_OFF) && !flags_ff.window_match_flag
    |=> !flags_ff.window_match_flag)
    else $error("Window match set with comparator off");

  ready_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc_end |=> flags_ff.result_ready_flag)
    else $error("Result ready not set with new result");

  ready_w1c_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_flags_write ##0 (pwdata[0] && !acc_end) |=> !flags_ff.result_ready_flag)
    else $error("Write one did not clear result ready");

  match_w1c_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_flags_write ##0 (pwdata[1] && !acc_end) |=> !flags_ff.window_match_flag)
    else $error("Write one did not clear window match");

  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    done_ph |-> (pslverr_ff == !a_mapped))
    else $error("Error response disagrees with address map");

  unmapped_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_done && !a_mapped |-> (prdata_ff == 32'h0000_0000))
    else $error("Unmapped read returned data");

  read_upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_done |-> (prdata_ff[31:8] == 24'h00_0000))
    else $error("Upper read data bits not zero");

  idle_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    !setup_ph |=> !pready_ff && !pslverr_ff)
    else $error("Bus answer without setup");

endmodule : adcw_top

`default_nettype wire

// ==== test/tb_adcw_top.sv ====
// Self-checking bench for the result, low threshold and flag registers
`timescale 1ns/10ps
`default_nettype none
module tb_adcw_top;
  import adcw_pkg::*;
  typedef struct packed {logic chk; logic err; logic [7:0] dat;} adcw_tb_exp_s;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, conv_valid;
  logic        [7:0]  paddr;
  logic        [31:0] pwdata, prdata;
  logic        [3:0]  pstrb;
  logic signed [11:0] conv_code;
  int                 n_mismatch, cmp_count, i;
  integer             seed;
  adcw_tb_exp_s       exp_q[$];
  adcw_tb_exp_s       ex;
  logic signed [11:0] code;

  adcw_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_valid(conv_valid), .conv_code(conv_code), .irq(irq));

  // Clock, 8 ns period
  always #4 pclk = ~pclk;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic fail(input string msg);
    n_mismatch++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask : fail

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // One APB transfer; the expected answer goes to the queue at setup
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d, input logic [7:0] e,
                     input logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, d};
    exp_q.push_back('{!wr, err, e});
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail("no ready");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 8'h00, 1'b0);
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00, e, 1'b0);
  endtask : rd

  // Low byte first, high byte comes from the shared temp
  task automatic rd_res(input logic [15:0] e);
    rd(ADCW_IDX_RES_LO, e[7:0]);
    rd(ADCW_IDX_RES_HI, e[15:8]);
  endtask : rd_res

  // Back-to-back conversion pulses of one code
  task automatic conv(input logic signed [11:0] c, input int n);
    repeat (n) begin
      @(posedge pclk);
      conv_valid <= 1'b1;
      conv_code  <= c;
    end
    @(posedge pclk);
    conv_valid <= 1'b0;
  endtask : conv

  task automatic chk_irq(input logic e);
    repeat (2) @(posedge pclk);
    cmp_count++;
    if (irq !== e) fail("irq level");
  endtask : chk_irq

  function automatic logic [15:0] clamp(input logic signed [11:0] c);
    if (c < 0) return 16'h0000;
    if (c > 12'sh3ff) return 16'h03ff;
    return {6'h00, c[9:0]};
  endfunction : clamp

  // Monitor: oldest note against each completed transfer
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      if (exp_q.size() == 0) begin
        fail("transfer without note");
      end else begin
        ex = exp_q.pop_front();
        cmp_count++;
        if (pslverr !== ex.err || (ex.chk && prdata !== {24'h000000, ex.dat}))
          fail($sformatf("index %0h read %0h err %0b", paddr[7:2], prdata, pslverr));
      end
    end
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    fail("timeout");
    report_and_stop();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 32279;
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0; pstrb = 4'hf; conv_valid = 0; conv_code = 12'sh000;
    n_mismatch = 0; cmp_count = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd_res(16'h0000);
    rd(ADCW_IDX_WLT_LO, 8'h00);
    rd(ADCW_IDX_WLT_HI, 8'h00);
    rd(ADCW_IDX_TEMP, 8'h00);
    wr(ADCW_IDX_WLT_LO, 8'h34);
    rd(ADCW_IDX_TEMP, 8'h34);
    wr(ADCW_IDX_WLT_HI, 8'h12);
    rd(ADCW_IDX_WLT_LO, 8'h34);
    rd(ADCW_IDX_WLT_HI, 8'h12);
    // Write without the low byte strobe leaves the temporary byte alone
    pstrb <= 4'he;
    wr(ADCW_IDX_TEMP, 8'h5a);
    pstrb <= 4'hf;
    rd(ADCW_IDX_TEMP, 8'h12);
    wr(ADCW_IDX_RES_LO, 8'hff);
    rd_res(16'h0000);
    apb(1'b0, 6'h3f, 8'h00, 8'h00, 1'b1); // Unmapped read refused
    // Single conversions: boundaries, negative, random
    wr(ADCW_IDX_CTRL, 8'h00);
    for (i = 0; i < 7; i++) begin
      code = (i == 0) ? 12'sh7ff : (i == 1) ? -12'sd5 : (i == 2) ? 12'sh3ff : 12'($random(seed));
      conv(code, 1);
      rd(ADCW_IDX_FLAGS, 8'h01);
      rd_res(clamp(code));
      rd(ADCW_IDX_FLAGS, 8'h00);
    end
    // 64 full-scale samples saturate at the top sum
    wr(ADCW_IDX_CTRL, 8'h06);
    conv(12'sh7ff, 63);
    rd(ADCW_IDX_FLAGS, 8'h00);
    conv(12'sh7ff, 1);
    rd_res(16'hffc0);
    // Below mode, threshold 0x0500, two samples: only the sum is compared
    wr(ADCW_IDX_WLT_LO, 8'h00);
    wr(ADCW_IDX_WLT_HI, 8'h05);
    wr(ADCW_IDX_CTRL, 8'h09);
    conv(12'sh300, 2);
    rd(ADCW_IDX_FLAGS, 8'h01);
    rd_res(16'h0600);
    // Single sample below threshold sets the match flag
    wr(ADCW_IDX_CTRL, 8'h08);
    conv(12'sh100, 1);
    rd(ADCW_IDX_FLAGS, 8'h03);
    wr(ADCW_IDX_MASK, 8'h02);
    chk_irq(1'b1);
    wr(ADCW_IDX_FLAGS, 8'h00);
    rd(ADCW_IDX_FLAGS, 8'h03);
    wr(ADCW_IDX_FLAGS, 8'h02);
    rd(ADCW_IDX_FLAGS, 8'h01);
    chk_irq(1'b0);
    wr(ADCW_IDX_MASK, 8'h01);
    chk_irq(1'b1);
    wr(ADCW_IDX_FLAGS, 8'h01);
    rd(ADCW_IDX_FLAGS, 8'h00);
    chk_irq(1'b0);
    // Above mode: a result under the threshold gives no match
    wr(ADCW_IDX_CTRL, 8'h10);
    conv(12'sh3ff, 1);
    rd(ADCW_IDX_FLAGS, 8'h01);
    wr(ADCW_IDX_CTRL, 8'h08);
    conv(12'sh010, 1);
    rd(ADCW_IDX_FLAGS, 8'h03);
    rd_res(16'h0010);
    rd(ADCW_IDX_FLAGS, 8'h00);
    // Above mode, two samples: sum 0x07fe passes the threshold
    wr(ADCW_IDX_CTRL, 8'h11);
    conv(12'sh3ff, 2);
    rd(ADCW_IDX_FLAGS, 8'h03);
    rd_res(16'h07fe);
    repeat (4) @(posedge pclk);
    report_and_stop();
  end
endmodule : tb_adcw_top
`default_nettype wire
